// *** rtl/bcib_ctrl.sv ***
// Interval timer, burst ROM sequencing and idle-state insertion of the bus controller
`timescale 1ns/1ps
module bcib_ctrl #(
   parameter int CNT_W = bcib_pkg::CNT_W_DEF
) (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // Interval timer control
   input  wire logic [2:0]                  dram_area_select_i,
   input  wire logic [2:0]                  counter_clock_select_i,
   input  wire logic                        match_irq_enable_i,
   input  wire logic                        match_flag_clr_i,
   input  wire logic                        hw_standby_i,
   input  wire logic                        sw_standby_i,
   input  wire logic                        cnt_wr_i,
   input  wire logic [CNT_W-1:0]            cnt_wdata_i,
   input  wire logic                        cmp_wr_i,
   input  wire logic [CNT_W-1:0]            cmp_wdata_i,
   // Interval timer status
   output logic      [CNT_W-1:0]            refresh_counter_o,
   output logic      [CNT_W-1:0]            refresh_compare_value_o,
   output logic                             match_flag_o,
   output logic                             compare_match_irq_o,
   output logic                             refresh_req_o,
   // Bus configuration
   input  wire logic                        burst_rom_enable_i,
   input  wire logic [bcib_pkg::N_AREA-1:0] access_state_control_i,
   input  wire logic                        burst_length_select_i,
   input  wire logic                        burst_state_select_i,
   input  wire logic                        idle_cfg_wr_i,
   input  wire logic                        idle_between_areas_enable_i,
   input  wire logic                        idle_write_after_read_enable_i,
   input  wire logic                        column_strobe_pin_select_i,
   input  wire logic                        ras_down_mode_i,
   input  wire logic [1:0]                  program_wait_i,
   input  wire logic                        wait_n_i,
   output logic      [1:0]                  idle_cfg_o,
   // Access requests
   input  wire logic                        req_valid_i,
   input  wire logic                        req_write_i,
   input  wire logic [2:0]                  req_area_i,
   input  wire logic [bcib_pkg::ADDR_W-1:0] req_addr_i,
   input  wire logic                        req_dram_i,
   input  wire logic                        req_precharge_i,
   input  wire logic [3:0]                  req_words_i,
   output logic                             req_ready_o,
   output logic                             word_done_o,
   // External bus pins
   output logic      [bcib_pkg::ADDR_W-1:0] addr_o,
   output logic      [bcib_pkg::N_AREA-1:0] chip_select_n_o,
   output logic                             address_strobe_n_o,
   output logic                             rd_n_o,
   output logic                             high_byte_write_strobe_n_o,
   output logic                             low_byte_write_strobe_n_o,
   output logic                             data_oe_n_o
);
   import bcib_pkg::*;

   // Counter width must lie between 2 and 16 bits
   if (CNT_W < 2 || CNT_W > 16) begin : g_chk
      $error("bcib_ctrl: CNT_W out of range");
   end

   typedef struct packed {
      bcib_st_t            st;
      logic [2:0]          ph;
      logic [1:0]          wcnt;
      logic [3:0]          words;
      logic                last_vld;
      logic                last_wr;
      logic                last_dram;
      logic [2:0]          last_area;
      logic                cur_wr;
      logic                cur_dram;
      logic [2:0]          cur_area;
      logic                cur_three;
      logic [1:0]          icfg;
      logic                ready;
      logic                done;
      logic [ADDR_W-1:0]   addr;
      logic [N_AREA-1:0]   cs_n;
      logic                as_n;
      logic                rd_n;
      logic                wr_n;
      logic                doe_n;
      logic [PRESC_W-1:0]  presc;
      logic                clk_lvl;
      logic [CNT_W-1:0]    cnt;
      logic [CNT_W-1:0]    cor;
      logic                flag;
      logic                irq;
      logic                rfsh;
   } bcib_state_t;

   bcib_state_t q;
   bcib_state_t d;
   logic        sel_lvl;
   logic        inc;
   logic        eq;
   logic        interval;
   logic        take;
   logic        need_ti;
   logic [2:0]  last_ph;
   logic [3:0]  bmax;

   // Timer and bus sequencer terms shared by the next-state logic and the checks
   always_comb begin
      sel_lvl  = (counter_clock_select_i == 3'h0) ? 1'b0
               : q.presc[CKS_TAP[counter_clock_select_i]];  // [R23]
      inc      = q.clk_lvl & ~sel_lvl & ~hw_standby_i;       // [R09] [R04]
      eq       = (q.cnt == q.cor);
      interval = (dram_area_select_i == 3'h0);               // [R01]
      take     = q.ready & req_valid_i;
      bmax     = burst_length_select_i ? BURST_MAX_LONG : BURST_MAX_SHORT;  // [R14]
      need_ti  = 1'b0;
      if (q.last_vld) begin
         if (q.last_dram && !req_dram_i && !column_strobe_pin_select_i) begin
            need_ti = 1'b1;                                  // [R19] [R20]
         end else if (!q.last_wr && !req_write_i && req_area_i != q.last_area) begin
            need_ti = q.icfg[1];                             // [R16]
         end else if (!q.last_wr && req_write_i) begin
            need_ti = q.icfg[0];                             // [R17]
         end
      end
      last_ph = q.cur_three ? LAST_PH_3 : LAST_PH_2;
   end

   // Next state of timer and bus sequencer
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.rfsh = 1'b0;
      // Prescaler halts with the rest of the timer in hardware standby
      if (!hw_standby_i) begin
         d.presc = q.presc + PRESC_W'(1);
      end
      d.clk_lvl = sel_lvl;
      // Clear beats write, write beats increment
      if (inc && eq) begin
         d.cnt = '0;                                         // [R24] [R06]
      end else if (cnt_wr_i) begin
         d.cnt = cnt_wdata_i;                                // [R07]
      end else if (inc) begin
         d.cnt = q.cnt + CNT_W'(1);
      end
      if (cmp_wr_i) begin
         d.cor = cmp_wdata_i;
      end
      // Match only on the count leaving the compare value; set beats clear
      if (inc && eq && !cmp_wr_i) begin                      // [R03] [R08]
         if (interval) begin
            d.flag = 1'b1;
         end else begin
            d.rfsh = 1'b1;
         end
      end else if (match_flag_clr_i) begin
         d.flag = 1'b0;
      end
      // Software standby wipes the count and flag, compare value survives
      if (sw_standby_i) begin
         d.cnt     = '0;                                     // [R05]
         d.flag    = 1'b0;
         d.presc   = '0;
         d.clk_lvl = 1'b0;
      end
      d.irq = d.flag & match_irq_enable_i & interval;        // [R10]
      if (idle_cfg_wr_i) begin
         d.icfg = {idle_between_areas_enable_i, idle_write_after_read_enable_i};
      end

      // Bus sequencer
      unique case (q.st)
         S_IDLE: begin
            if (take) begin
               d.cur_wr    = req_write_i;
               d.cur_dram  = req_dram_i;
               d.cur_area  = req_area_i;
               d.cur_three = access_state_control_i[req_area_i];  // [R12]
               d.addr      = req_addr_i;
               d.ph        = '0;
               d.wcnt      = '0;
               d.words     = ONE_WORD;
               // Burst only for reads of area 0 with burst ROM on
               if (burst_rom_enable_i && req_area_i == 3'h0 && !req_write_i
                   && !req_dram_i && req_words_i > ONE_WORD) begin  // [R11]
                  d.words = (req_words_i > bmax) ? bmax : req_words_i;
               end
               if (req_dram_i && req_precharge_i) begin
                  d.st = S_TP;                               // [R21]
               end else if (need_ti) begin
                  d.st = S_TI;
               end else begin
                  d.st = S_ACC;
               end
            end else begin
               d.last_vld = 1'b0;
            end
         end
         S_TI, S_TP: begin
            d.st = S_ACC;
         end
         S_ACC: begin
            // Waits only in three-state first access, never in burst
            if (q.ph < last_ph) begin
               d.ph = q.ph + 3'h1;
            end else if (q.cur_three && (q.wcnt < program_wait_i || !wait_n_i)) begin
               if (q.wcnt < program_wait_i) begin
                  d.wcnt = q.wcnt + 2'h1;                    // [R12]
               end
            end else begin
               d.done  = 1'b1;
               d.ph    = '0;
               d.words = q.words - ONE_WORD;
               if (q.words > ONE_WORD) begin
                  d.st   = S_BUR;
                  d.addr = q.addr + WORD_STEP;
               end else begin
                  d.st = S_IDLE;
               end
            end
         end
         S_BUR: begin
            // Fixed length, wait pin ignored
            if (q.ph < (burst_state_select_i ? LAST_PH_3 : LAST_PH_2)) begin  // [R15] [R13]
               d.ph = q.ph + 3'h1;
            end else begin
               d.done  = 1'b1;
               d.ph    = '0;
               d.words = q.words - ONE_WORD;
               if (q.words > ONE_WORD) begin
                  d.addr = q.addr + WORD_STEP;
               end else begin
                  d.st = S_IDLE;
               end
            end
         end
      endcase
      if (d.st == S_IDLE && q.st != S_IDLE) begin
         d.last_vld  = 1'b1;
         d.last_wr   = q.cur_wr;
         d.last_dram = q.cur_dram;
         d.last_area = q.cur_area;
      end
      d.ready = (d.st == S_IDLE) && !take;

      // Pin levels for the coming state; idle keeps strobes high
      d.cs_n  = '1;
      d.as_n  = 1'b1;
      d.rd_n  = 1'b1;
      d.wr_n  = 1'b1;
      d.doe_n = 1'b1;                                        // [R22]
      if (d.st == S_ACC || d.st == S_BUR) begin
         d.cs_n[d.cur_area] = 1'b0;
         d.as_n  = (d.st == S_BUR);
         d.rd_n  = d.cur_wr;
         d.wr_n  = ~d.cur_wr;
         d.doe_n = ~d.cur_wr;
      end else if (d.st == S_TI && ras_down_mode_i && q.last_dram) begin
         d.cs_n[q.last_area] = 1'b0;                         // [R22]
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q       <= '0;
         q.st    <= S_IDLE;
         q.icfg  <= IDLE_CFG_RST;                            // [R18]
         q.ready <= 1'b1;
         q.cs_n  <= '1;
         q.as_n  <= 1'b1;
         q.rd_n  <= 1'b1;
         q.wr_n  <= 1'b1;
         q.doe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign refresh_counter_o          = q.cnt;
   assign refresh_compare_value_o    = q.cor;
   assign match_flag_o               = q.flag;
   assign compare_match_irq_o        = q.irq;
   assign refresh_req_o              = q.rfsh;
   assign idle_cfg_o                 = q.icfg;
   assign req_ready_o                = q.ready;
   assign word_done_o                = q.done;
   assign addr_o                     = q.addr;
   assign chip_select_n_o            = q.cs_n;
   assign address_strobe_n_o         = q.as_n;
   assign rd_n_o                     = q.rd_n;
   assign high_byte_write_strobe_n_o = q.wr_n;
   assign low_byte_write_strobe_n_o  = q.wr_n;
   assign data_oe_n_o                = q.doe_n;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_match_clear: assert property ((inc && eq && !cmp_wr_i && !sw_standby_i)
      |=> refresh_counter_o == '0 && (match_flag_o || refresh_req_o))  // [R03] [R24]
      else $error("match did not clear counter or set flag");
   a_clear_wins: assert property ((inc && eq && cnt_wr_i && !sw_standby_i)
      |=> refresh_counter_o == '0)  // [R06]
      else $error("counter write beat clear");
   a_write_wins: assert property ((cnt_wr_i && inc && !eq && !sw_standby_i)
      |=> refresh_counter_o == $past(cnt_wdata_i))  // [R07]
      else $error("increment beat counter write");
   a_cor_inhibit: assert property ((cmp_wr_i && inc && eq && !match_flag_o)
      |=> !match_flag_o && !refresh_req_o)  // [R08]
      else $error("match not suppressed by compare write");
   a_sw_standby: assert property (sw_standby_i
      |=> refresh_counter_o == '0 && !match_flag_o
          && refresh_compare_value_o == $past(refresh_compare_value_o))  // [R05]
      else $error("software standby state wrong");
   a_hw_stop: assert property ((hw_standby_i && !sw_standby_i && !cnt_wr_i)
      |=> $stable(refresh_counter_o))  // [R04]
      else $error("counter moved in hardware standby");
   a_irq_mask: assert property ((!match_irq_enable_i || dram_area_select_i != 3'h0)
      |=> !compare_match_irq_o)  // [R10]
      else $error("interrupt not masked");
   a_wr_after_rd: assert property ((take && req_write_i && q.last_vld && !q.last_wr
      && q.icfg[0] && !req_dram_i) |=> q.st == S_TI ##1 q.st == S_ACC)  // [R17]
      else $error("no idle before write after read");
   a_forced_idle: assert property ((take && q.last_vld && q.last_dram && !req_dram_i
      && !column_strobe_pin_select_i) |=> q.st == S_TI)  // [R19]
      else $error("no forced idle after DRAM access");
   a_precharge_only: assert property ((take && req_dram_i && req_precharge_i)
      |=> q.st == S_TP ##1 q.st == S_ACC)  // [R21]
      else $error("idle added to precharge");
   a_idle_pins: assert property ((q.st == S_TI)
      |-> rd_n_o && address_strobe_n_o && high_byte_write_strobe_n_o
          && data_oe_n_o && addr_o == $past(req_addr_i))  // [R22]
      else $error("pins active during idle");
   a_burst_nowait: assert property ((q.st == S_BUR && q.ph == 3'h0 && !burst_state_select_i)
      |=> q.ph == 3'h1 ##1 q.ph == 3'h0 || q.st == S_IDLE)  // [R15] [R13]
      else $error("two-state burst cycle stretched");

   c_match_irq: cover property (compare_match_irq_o);
   c_idle_state: cover property (q.st == S_TI);
   c_burst_eight: cover property (q.st == S_BUR && q.words == BURST_MAX_LONG - ONE_WORD);
   c_precharge: cover property (q.st == S_TP);
endmodule

// *** rtl/bcib_pkg.sv ***
// Constants and types shared by the bus controller interval, burst and idle block
// Contract
// [R01] Area select zero makes counter an interval timer
// [R02] Software sets compare, clock, then interrupt enable
// [R03] Match flag set when counter leaves match
// [R04] Counts in sleep, stops in hardware standby
// [R05] Software standby clears counter and flag only
// [R06] Clear beats counter write in same cycle
// [R07] Counter write beats coincident increment
// [R08] Compare write suppresses coincident compare match
// [R09] Count on falling edge of selected clock
// [R10] Interrupt request only while enable set
// [R11] Burst enable makes area zero burst ROM
// [R12] First access follows area zero state bit
// [R13] No wait states in burst cycles
// [R14] Burst maximum four or eight words
// [R15] Burst cycle two or three states
// [R16] Idle before read to different area
// [R17] Idle before write following a read
// [R18] Both idle enables reset to one
// [R19] Forced idle after DRAM with write strobes
// [R20] No forced idle with port pin strobes
// [R21] Precharge replaces idle before DRAM access
// [R22] Idle state: next address, strobes high
// [R23] Counting starts once clock select nonzero
// [R24] Compare match clears counter to zero
package bcib_pkg;
   localparam int CNT_W_DEF = 8;
   localparam int PRESC_W = 12;
   localparam int ADDR_W = 24;
   localparam int N_AREA = 8;
   // Prescaler bit watched for each clock select code; code 0 halts
   localparam int unsigned CKS_TAP [0:7] = '{0, 0, 1, 3, 5, 7, 9, 11};
   localparam logic [3:0] BURST_MAX_SHORT = 4'h4;
   localparam logic [3:0] BURST_MAX_LONG = 4'h8;
   localparam logic [3:0] ONE_WORD = 4'h1;
   localparam logic [2:0] LAST_PH_2 = 3'h1;
   localparam logic [2:0] LAST_PH_3 = 3'h2;
   localparam logic [23:0] WORD_STEP = 24'h000002;
   localparam logic [1:0] IDLE_CFG_RST = 2'h3;
   typedef enum logic [2:0] {S_IDLE, S_TI, S_TP, S_ACC, S_BUR} bcib_st_t;
endpackage

// *** test/bcib_mem_model.sv ***
// Far-side memory model answering with the wait pin, prompt or slow
`timescale 1ns/1ps
module bcib_mem_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Bus pins seen from the memory
   input  wire logic [7:0] chip_select_n_i,
   input  wire logic       done_i,
   // Answer speed and wait output
   input  wire logic [1:0] slow_i,
   output logic            wait_n_o
);
   logic [1:0] hold_q;
   logic       sel_q;
   // Restart the hold on each new select and each word, so bursts see waits too
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hold_q <= 2'h0;
         sel_q  <= 1'b0;
      end else begin
         sel_q <= ~&chip_select_n_i;
         if ((~&chip_select_n_i && !sel_q) || done_i) begin
            hold_q <= slow_i;
         end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
         end
      end
   end
   // Wait only while selected; a released wait line sits high on its pull-up
   assign wait_n_o = !(hold_q != 2'h0 && ~&chip_select_n_i);
endmodule

// *** test/tb_bcib_ctrl.sv ***
// Self-checking bench for interval timer, burst ROM and idle insertion
`timescale 1ns/1ps
module tb_bcib_ctrl;
   import bcib_pkg::*;
   localparam int CV = 3;
   // Design stimulus and observation
   logic clk_i, rst_n_i, match_irq_enable_i, match_flag_clr_i, hw_standby_i, sw_standby_i;
   logic cnt_wr_i, cmp_wr_i, burst_rom_enable_i, burst_length_select_i, burst_state_select_i;
   logic idle_cfg_wr_i, idle_between_areas_enable_i, idle_write_after_read_enable_i;
   logic column_strobe_pin_select_i, ras_down_mode_i, wait_n_i, req_valid_i, req_write_i;
   logic req_dram_i, req_precharge_i, match_flag_o, compare_match_irq_o, refresh_req_o;
   logic req_ready_o, word_done_o, address_strobe_n_o, rd_n_o, data_oe_n_o;
   logic high_byte_write_strobe_n_o, low_byte_write_strobe_n_o, idle_ok, saw;
   logic [2:0]  dram_area_select_i, counter_clock_select_i, req_area_i;
   logic [7:0]  cnt_wdata_i, cmp_wdata_i, refresh_counter_o, refresh_compare_value_o, v;
   logic [7:0]  access_state_control_i, chip_select_n_o;
   logic [1:0]  program_wait_i, idle_cfg_o, slow;
   logic [3:0]  req_words_i;
   logic [23:0] req_addr_i, addr_o;
   logic [31:0] seed, aw;
   int          err_total, n_checks, lead, first, nd, gmin, gmax, t;

   bcib_ctrl bcib_ctrl_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .dram_area_select_i(dram_area_select_i),
      .counter_clock_select_i(counter_clock_select_i), .match_irq_enable_i(match_irq_enable_i),
      .match_flag_clr_i(match_flag_clr_i), .hw_standby_i(hw_standby_i),
      .sw_standby_i(sw_standby_i), .cnt_wr_i(cnt_wr_i), .cnt_wdata_i(cnt_wdata_i),
      .cmp_wr_i(cmp_wr_i), .cmp_wdata_i(cmp_wdata_i), .refresh_counter_o(refresh_counter_o),
      .refresh_compare_value_o(refresh_compare_value_o), .match_flag_o(match_flag_o),
      .compare_match_irq_o(compare_match_irq_o), .refresh_req_o(refresh_req_o),
      .burst_rom_enable_i(burst_rom_enable_i), .access_state_control_i(access_state_control_i),
      .burst_length_select_i(burst_length_select_i), .idle_cfg_wr_i(idle_cfg_wr_i),
      .burst_state_select_i(burst_state_select_i), .ras_down_mode_i(ras_down_mode_i),
      .idle_between_areas_enable_i(idle_between_areas_enable_i), .idle_cfg_o(idle_cfg_o),
      .idle_write_after_read_enable_i(idle_write_after_read_enable_i), .wait_n_i(wait_n_i),
      .column_strobe_pin_select_i(column_strobe_pin_select_i), .program_wait_i(program_wait_i),
      .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_area_i(req_area_i),
      .req_addr_i(req_addr_i), .req_dram_i(req_dram_i), .req_precharge_i(req_precharge_i),
      .req_words_i(req_words_i), .req_ready_o(req_ready_o), .word_done_o(word_done_o),
      .addr_o(addr_o), .chip_select_n_o(chip_select_n_o), .rd_n_o(rd_n_o),
      .address_strobe_n_o(address_strobe_n_o), .data_oe_n_o(data_oe_n_o),
      .high_byte_write_strobe_n_o(high_byte_write_strobe_n_o),
      .low_byte_write_strobe_n_o(low_byte_write_strobe_n_o)
   );
   bcib_mem_model bcib_mem_model_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(chip_select_n_o),
      .done_i(word_done_o), .slow_i(slow), .wait_n_o(wait_n_i)
   );

   // 125 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Burst length is capped by the selected maximum
   function automatic int nwords(int w, logic l);
      return (w > (l ? 8 : 4)) ? (l ? 8 : 4) : w;
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Wait for the match flag, noting whether the counter sat at the compare value
   task automatic wflag();
      saw = 1'b0;
      t = 0;
      while (match_flag_o !== 1'b1 && t < 200) begin
         if (refresh_counter_o === CV[7:0]) saw = 1'b1;
         @(posedge clk_i);
         t++;
      end
   endtask
   // One access: hold the request until taken, then time select, idle pins and words
   task automatic acc(input logic wr, input logic [2:0] ar, input logic dr, input logic pr,
                      input logic [3:0] w, input logic m);
      int k;
      int last;
      aw = rnd();
      req_write_i <= wr;
      req_area_i <= ar;
      req_dram_i <= dr;
      req_precharge_i <= pr;
      req_words_i <= w;
      req_addr_i <= {8'h00, aw[15:1], 1'b0};
      req_valid_i <= 1'b1;
      k = 0;
      @(posedge clk_i);
      while (req_ready_o !== 1'b1 && k < 50) begin
         @(posedge clk_i);
         k++;
      end
      // Unwatched access keeps valid up so the next one lands back to back
      if (!m) return;
      req_valid_i <= 1'b0;
      {lead, first, nd, gmax, last, k} = '0;
      gmin = 99;
      do begin
         @(posedge clk_i);
         k++;
         if (lead == 0 && chip_select_n_o !== 8'hFF) lead = k;
         if (k == 1) idle_ok = chip_select_n_o === 8'hFF && rd_n_o === 1'b1 &&
            address_strobe_n_o === 1'b1 && high_byte_write_strobe_n_o === 1'b1 &&
            low_byte_write_strobe_n_o === 1'b1 && data_oe_n_o === 1'b1 && addr_o === req_addr_i;
         if (word_done_o === 1'b1) begin
            if (nd == 0) first = k - lead;
            if (nd > 0 && k - last < gmin) gmin = k - last;
            if (nd > 0 && k - last > gmax) gmax = k - last;
            last = k;
            nd++;
         end
      end while (req_ready_o !== 1'b1 && k < 60);
      chk("bus_end", 1, k < 60);
   endtask
   // Back-to-back pair under a given idle setup; ex is cycles from take to select
   task automatic pair(input int pw, input int pa, input int pd, input int nw, input int na,
                       input int ndr, input int np, input int ba, input int war, input int cs,
                       input int ex);
      column_strobe_pin_select_i <= 1'(cs);
      idle_between_areas_enable_i <= 1'(ba);
      idle_write_after_read_enable_i <= 1'(war);
      idle_cfg_wr_i <= 1'b1;
      @(posedge clk_i);
      idle_cfg_wr_i <= 1'b0;
      cyc(3);
      chk("idle_cfg", {ba[0], war[0]}, idle_cfg_o);
      acc(1'(pw), 3'(pa), 1'(pd), 1'b0, 4'h1, 1'b0);
      acc(1'(nw), 3'(na), 1'(ndr), 1'(np), 4'h1, 1'b1);
      chk("lead", ex, lead);
      if (ex == 2 && np == 0) chk("idle_pins", 1, idle_ok);
   endtask

   // Hang guard, well beyond the planned run
   initial begin
      cyc(20000);
      err_total++;
      summarize();
   end

   // Main sequence
   initial begin
      seed = 32'h00000014;
      {err_total, n_checks} = '0;
      rst_n_i = 1'b0;
      {dram_area_select_i, counter_clock_select_i, match_irq_enable_i, match_flag_clr_i,
       hw_standby_i, sw_standby_i, cnt_wr_i, cnt_wdata_i, cmp_wr_i, cmp_wdata_i,
       burst_rom_enable_i, access_state_control_i, burst_length_select_i, burst_state_select_i,
       idle_cfg_wr_i, idle_between_areas_enable_i, idle_write_after_read_enable_i,
       column_strobe_pin_select_i, ras_down_mode_i, program_wait_i, req_valid_i, req_write_i,
       req_area_i, req_addr_i, req_dram_i, req_precharge_i, req_words_i, slow} = '0;
      cyc(3);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk("idle_cfg_rst", 32'h3, idle_cfg_o);
      chk("ready_rst", 32'h1, req_ready_o);
      $display("test reset done");
      // Compare first, then clock source, then interrupt enable
      cmp_wdata_i <= CV;
      cmp_wr_i <= 1'b1;
      @(posedge clk_i);
      cmp_wr_i <= 1'b0;
      counter_clock_select_i <= 3'h1;
      @(posedge clk_i);
      match_irq_enable_i <= 1'b1;
      wflag();
      chk("eq_before_match", 1, saw);
      chk("cnt_cleared", 0, refresh_counter_o);
      chk("irq_on", 1, compare_match_irq_o);
      match_flag_clr_i <= 1'b1;
      @(posedge clk_i);
      match_flag_clr_i <= 1'b0;
      @(posedge clk_i);
      wflag();
      chk("period", 2 * (CV + 1) - 2, t);
      match_irq_enable_i <= 1'b0;
      cyc(2);
      chk("irq_masked", 0, compare_match_irq_o);
      // Repeated counter writes hide every coinciding increment
      cnt_wdata_i <= 8'(rnd() % CV);
      cnt_wr_i <= 1'b1;
      cyc(4);
      cnt_wr_i <= 1'b0;
      @(posedge clk_i);
      chk("cnt_write_wins", cnt_wdata_i, refresh_counter_o);
      hw_standby_i <= 1'b1;
      cyc(2);
      v = refresh_counter_o;
      cyc(10);
      chk("hw_standby_hold", v, refresh_counter_o);
      hw_standby_i <= 1'b0;
      sw_standby_i <= 1'b1;
      cyc(2);
      chk("sw_cnt", 0, refresh_counter_o);
      chk("sw_flag", 0, match_flag_o);
      chk("sw_cmp", CV, refresh_compare_value_o);
      sw_standby_i <= 1'b0;
      // Compare writes held through every match keep the flag down
      cmp_wr_i <= 1'b1;
      cyc(40);
      chk("match_masked", 0, match_flag_o);
      cmp_wr_i <= 1'b0;
      counter_clock_select_i <= 3'h0;
      cyc(2);
      v = refresh_counter_o;
      cyc(10);
      chk("halted", v, refresh_counter_o);
      cnt_wdata_i <= 8'h00;
      cnt_wr_i <= 1'b1;
      match_flag_clr_i <= 1'b1;
      @(posedge clk_i);
      cnt_wr_i <= 1'b0;
      match_flag_clr_i <= 1'b0;
      dram_area_select_i <= 3'h1;
      counter_clock_select_i <= 3'h1;
      saw = 1'b0;
      for (int i = 0; i < 100; i++) begin
         @(posedge clk_i);
         if (refresh_req_o === 1'b1) saw = 1'b1;
      end
      chk("refresh_req", 1, saw);
      chk("no_flag_refresh", 0, match_flag_o);
      dram_area_select_i <= 3'h0;
      counter_clock_select_i <= 3'h0;
      $display("test timer done");
      pair(0, 1, 0, 0, 2, 0, 0, 1, 1, 1, 2);
      pair(0, 1, 0, 0, 2, 0, 0, 0, 0, 1, 1);
      pair(0, 1, 0, 0, 1, 0, 0, 1, 1, 1, 1);
      pair(0, 1, 0, 1, 1, 0, 0, 0, 1, 1, 2);
      pair(0, 1, 0, 1, 1, 0, 0, 1, 0, 1, 1);
      pair(0, 2, 1, 0, 3, 0, 0, 0, 0, 0, 2);
      pair(0, 2, 1, 0, 3, 0, 0, 0, 0, 1, 1);
      pair(0, 1, 0, 0, 2, 1, 1, 1, 1, 1, 2);
      $display("test idle done");
      // Bursts with a slow memory pulling wait on every word
      burst_rom_enable_i <= 1'b1;
      slow <= 2'h2;
      for (int i = 0; i < 8; i++) begin
         logic [3:0] w;
         w = 4'(rnd() % 14 + 2);
         burst_length_select_i <= 1'(i);
         burst_state_select_i <= 1'(i >> 1);
         access_state_control_i <= {7'(rnd()), 1'(i >> 2)};
         program_wait_i <= 2'(rnd() % 3 + 1);
         cyc(3);
         acc(1'b0, 3'h0, 1'b0, 1'b0, w, 1'b1);
         chk("words", nwords(w, 1'(i)), nd);
         chk("gap_min", i[1] ? 3 : 2, gmin);
         chk("gap_max", i[1] ? 3 : 2, gmax);
         if (i[2]) chk("first_long", 1, first > 3);
         else chk("first_short", 2, first);
      end
      $display("test burst done");
      summarize();
   end
endmodule
